// ---- pkg/tlc_pkg.sv ----
// Constants for the two-way tag store controller
package tlc_pkg;
  localparam int INDEX_W = 13;
  localparam int TAG_W = 4;
  localparam int CNT_W = 4;
  localparam int CLK_NS = 10;
  localparam int SYNC_STAGES = 2;
  // Pin timing in ns, cycle counts derived (least times round up)
  localparam int SETTLE_NS = 30;
  localparam int W_PULSE_NS = 30;
  localparam int RW_PULSE_NS = 30;
  localparam int RECOVER_NS = 20;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOOKUP_CYC = SETTLE_CYC + SYNC_STAGES;
  localparam int W_PULSE_CYC = (W_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RW_PULSE_CYC = (RW_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  // Reset values of the pin drivers
  localparam logic [INDEX_W-1:0] INDEX_RST = 13'h0000;
  localparam logic [TAG_W-1:0] TAG_RST = 4'h0;
  localparam logic WAY1 = 1'b0;
  localparam logic WAY2 = 1'b1;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETTLE, ST_DECIDE, ST_RECENCY, ST_WRITE, ST_RECOVER
  } tlc_state_t;
endpackage

// ---- design/tlc_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module tlc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] q_d;

  if (WIDTH < 1) begin : g_chk
    $error("tlc_sync width must be at least 1");
  end

  // Next values
  always_comb begin
    meta_d = d;
    q_d = meta_q;
    if (!rst_n) begin
      meta_d = '0;
      q_d = '0;
    end
  end

  // Two stages, first read only by second
  always_ff @(posedge clk_sys) begin
    meta_q <= meta_d;
    q <= q_d;
  end
endmodule

// ---- design/tlc_ctrl.sv ----
// Cache controller driving a two-way tag comparator with recency store
// Overview of operation
// - Controller never rewrites the tag on a hit.
// - On a filling miss, data goes to the way replace_way names.
// - On a write hit, data way follows the hit output that is high.
// - Cascaded slices need wire-ANDed hit outputs for recency writes.
`timescale 1ns/1ns
module tlc_ctrl
  import tlc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  // User side
  input wire logic req_valid,
  input wire logic req_fill,
  input wire logic [tlc_pkg::INDEX_W-1:0] req_index,
  input wire logic [tlc_pkg::TAG_W-1:0] req_tag,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_hit,
  output logic rsp_way,
  output logic rsp_written,
  // Device pins
  output logic [tlc_pkg::INDEX_W-1:0] index_lines,
  output logic [tlc_pkg::TAG_W-1:0] tag_lines_o,
  output logic tag_lines_oe,
  input wire logic [tlc_pkg::TAG_W-1:0] tag_lines_i,
  output logic select_n,
  output logic write_strobe_n,
  output logic recency_write_n,
  input wire logic way1_hit,
  input wire logic way2_hit,
  input wire logic replace_way
);
  import tlc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (LOOKUP_CYC > (1 << CNT_W) || W_PULSE_CYC > (1 << CNT_W) ||
      RW_PULSE_CYC > (1 << CNT_W) || RECOVER_CYC > (1 << CNT_W)) begin : g_chk
    $error("tlc_ctrl timing count exceeds counter width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  logic [2:0] pins_s;
  logic h1_s;
  logic h2_s;
  logic rw_s;

  // Cascaded slices arrive already wire-ANDed, one hit input per way
  tlc_sync #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({replace_way, way2_hit, way1_hit}),
    .q(pins_s)
  );

  // Synchronised pin levels
  assign h1_s = pins_s[0];
  assign h2_s = pins_s[1];
  assign rw_s = pins_s[2];

  function automatic logic [CNT_W-1:0] cnt_load(input int cyc);
    cnt_load = CNT_W'(cyc - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  tlc_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [INDEX_W-1:0] index_q, index_d;
  logic [TAG_W-1:0] tag_q, tag_d;
  logic sel_n_q, sel_n_d;
  logic ws_n_q, ws_n_d;
  logic rwr_n_q, rwr_n_d;
  logic fill_q, fill_d;
  logic ready_q, ready_d;
  logic rv_q, rv_d;
  logic hit_q, hit_d;
  logic way_q, way_d;
  logic wr_q, wr_d;

  // Next-state and pin sequencing
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    index_d = index_q;
    tag_d = tag_q;
    sel_n_d = sel_n_q;
    ws_n_d = ws_n_q;
    rwr_n_d = rwr_n_q;
    fill_d = fill_q;
    ready_d = ready_q;
    rv_d = 1'b0;
    hit_d = hit_q;
    way_d = way_q;
    wr_d = wr_q;
    case (st_q)
      ST_IDLE: begin
        if (req_valid && ready_q) begin
          // Apply index, tag and select together on the same edge
          index_d = req_index;
          tag_d = req_tag;
          fill_d = req_fill;
          sel_n_d = 1'b0;
          ready_d = 1'b0;
          cnt_d = cnt_load(LOOKUP_CYC);
          st_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // Wait for comparator delay plus synchroniser
        if (cnt_q == '0) begin
          st_d = ST_DECIDE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_DECIDE: begin
        hit_d = h1_s | h2_s;
        wr_d = 1'b0;
        if (h1_s || h2_s) begin
          way_d = h1_s ? WAY1 : WAY2;
          rwr_n_d = 1'b0;
          cnt_d = cnt_load(RW_PULSE_CYC);
          st_d = ST_RECENCY;
        end else if (fill_q) begin
          // Replace way sampled before the strobe falls
          way_d = rw_s;
          wr_d = 1'b1;
          ws_n_d = 1'b0;
          cnt_d = cnt_load(W_PULSE_CYC);
          st_d = ST_WRITE;
        end else begin
          way_d = rw_s;
          sel_n_d = 1'b1;
          cnt_d = cnt_load(RECOVER_CYC);
          st_d = ST_RECOVER;
        end
      end
      ST_RECENCY: begin
        // Recency pulse, hit outputs held by steady inputs
        if (cnt_q == '0) begin
          rwr_n_d = 1'b1;
          sel_n_d = 1'b1;
          cnt_d = cnt_load(RECOVER_CYC);
          st_d = ST_RECOVER;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_WRITE: begin
        // Single strobe low period, select stays low
        if (cnt_q == '0) begin
          ws_n_d = 1'b1;
          sel_n_d = 1'b1;
          cnt_d = cnt_load(RECOVER_CYC);
          st_d = ST_RECOVER;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_RECOVER: begin
        if (cnt_q == '0) begin
          rv_d = 1'b1;
          ready_d = 1'b1;
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        st_d = ST_IDLE;
        sel_n_d = 1'b1;
        ws_n_d = 1'b1;
        rwr_n_d = 1'b1;
        ready_d = 1'b1;
      end
    endcase
    if (!rst_n) begin
      st_d = ST_IDLE;
      cnt_d = '0;
      index_d = INDEX_RST;
      tag_d = TAG_RST;
      sel_n_d = 1'b1;
      ws_n_d = 1'b1;
      rwr_n_d = 1'b1;
      fill_d = 1'b0;
      ready_d = 1'b1;
      rv_d = 1'b0;
      hit_d = 1'b0;
      way_d = WAY1;
      wr_d = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    st_q <= st_d;
    cnt_q <= cnt_d;
    index_q <= index_d;
    tag_q <= tag_d;
    sel_n_q <= sel_n_d;
    ws_n_q <= ws_n_d;
    rwr_n_q <= rwr_n_d;
    fill_q <= fill_d;
    ready_q <= ready_d;
    rv_q <= rv_d;
    hit_q <= hit_d;
    way_q <= way_d;
    wr_q <= wr_d;
  end

  // Outputs straight from flops; tag lines always driven by us
  assign index_lines = index_q;
  assign tag_lines_o = tag_q;
  assign tag_lines_oe = 1'b1;
  assign select_n = sel_n_q;
  assign write_strobe_n = ws_n_q;
  assign recency_write_n = rwr_n_q;
  assign req_ready = ready_q;
  assign rsp_valid = rv_q;
  assign rsp_hit = hit_q;
  assign rsp_way = way_q;
  assign rsp_written = wr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_wpulse;
    !ws_n_q [*3] ##1 ws_n_q;
  endsequence

  property p_no_write_on_hit;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(ws_n_q) |-> $past(st_q == ST_DECIDE) && !$past(h1_s || h2_s);
  endproperty
  a_no_write_on_hit: assert property (p_no_write_on_hit)
    else $error("tag write started on a hit");

  property p_miss_way;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == ST_DECIDE && !h1_s && !h2_s) |=> (way_q == $past(rw_s));
  endproperty
  a_miss_way: assert property (p_miss_way)
    else $error("miss way differs from replace_way");

  property p_hit_way;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == ST_DECIDE && (h1_s || h2_s)) |=>
        (way_q == ($past(h1_s) ? WAY1 : WAY2)) && hit_q;
  endproperty
  a_hit_way: assert property (p_hit_way)
    else $error("hit way not taken from hit outputs");

  property p_one_write_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(ws_n_q) |-> s_wpulse ##1 ws_n_q [*2];
  endproperty
  a_one_write_pulse: assert property (p_one_write_pulse)
    else $error("write strobe pulse malformed");

  property p_recency_on_hit;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(rwr_n_q) |-> $past(h1_s || h2_s) && !sel_n_q && ws_n_q;
  endproperty
  a_recency_on_hit: assert property (p_recency_on_hit)
    else $error("recency write without selected hit");

  property p_tag_stable;
    @(posedge clk_sys) disable iff (!rst_n)
      !ws_n_q |-> $stable(tag_q) && $stable(index_q) && !sel_n_q;
  endproperty
  a_tag_stable: assert property (p_tag_stable)
    else $error("tag or index moved during write");
endmodule

// ---- bench/tlc_dev_model.sv ----
// Behavioural model of the two-way tag store with recency bits
`timescale 1ns/1ns
module tlc_dev_model
  import tlc_pkg::*;
#(
  parameter int HIT_DLY = 25
) (
  input wire logic [tlc_pkg::INDEX_W-1:0] index_lines,
  input wire logic [tlc_pkg::TAG_W-1:0] tag_lines,
  input wire logic select_n,
  input wire logic write_strobe_n,
  input wire logic recency_write_n,
  output logic way1_hit,
  output logic way2_hit,
  output logic replace_way
);
  // Two tag arrays with parity and one recency array, cleared as after reset
  logic [4:0] way1_mem [8192];
  logic [4:0] way2_mem [8192];
  logic recency [8192];
  int n_writes = 0;
  logic forced;

  // Cleared contents, as after a device reset
  initial begin
    for (int i = 0; i < 8192; i++) begin
      way1_mem[i] = 5'h00;
      way2_mem[i] = 5'h00;
      recency[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare paths, forced high while deselected or writing
  // Tag lines are only ever inputs here, so the model never drives them while writing
  assign forced = select_n | ~write_strobe_n;
  assign #(HIT_DLY) way1_hit = forced | (way1_mem[index_lines][3:0] == tag_lines);
  assign #(HIT_DLY) way2_hit = forced | (way2_mem[index_lines][3:0] == tag_lines);

  // Replacement way, frozen while the strobe is low
  always_latch begin
    if (write_strobe_n) begin
      replace_way <= recency[index_lines];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One self-timed write per strobe fall, way picked by recency
  always @(negedge write_strobe_n) begin
    if (recency[index_lines]) begin
      way2_mem[index_lines] <= {^tag_lines, tag_lines};
    end else begin
      way1_mem[index_lines] <= {^tag_lines, tag_lines};
    end
    recency[index_lines] <= ~recency[index_lines];
    n_writes <= n_writes + 1;
  end

  // Recency write from own hit outputs, ignored while they are forced
  always @(negedge recency_write_n) begin
    if (!forced && (way1_hit || way2_hit)) begin
      recency[index_lines] <= way1_hit;
    end
  end
endmodule

// ---- bench/tlc_ctrl_tb.sv ----
// Self-checking bench for the tag store controller
`timescale 1ns/1ns
module tlc_ctrl_tb;
  import tlc_pkg::*;
  localparam logic [12:0] IDX_HI = 13'h1FFF;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_fill = 1'b0;
  logic [INDEX_W-1:0] req_index = 13'h0000;
  logic [TAG_W-1:0] req_tag = 4'h0;
  logic req_ready, rsp_valid, rsp_hit, rsp_way, rsp_written;
  logic [INDEX_W-1:0] index_lines;
  logic [TAG_W-1:0] tag_lines_o, tag_bus;
  logic tag_lines_oe, select_n, write_strobe_n, recency_write_n;
  logic way1_hit, way2_hit, replace_way;
  int mismatches = 0;
  int n_checks = 0;

  // Tag wire: driven value, else a pattern that never holds the old value
  assign tag_bus = tag_lines_oe ? tag_lines_o : ~tag_lines_o;

  tlc_ctrl tlc_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req_fill(req_fill), .req_index(req_index), .req_tag(req_tag), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_way(rsp_way), .rsp_written(rsp_written),
    .index_lines(index_lines), .tag_lines_o(tag_lines_o), .tag_lines_oe(tag_lines_oe),
    .tag_lines_i(tag_bus), .select_n(select_n), .write_strobe_n(write_strobe_n),
    .recency_write_n(recency_write_n), .way1_hit(way1_hit), .way2_hit(way2_hit),
    .replace_way(replace_way));

  tlc_dev_model tlc_dev_model_inst (.index_lines(index_lines), .tag_lines(tag_bus),
    .select_n(select_n), .write_strobe_n(write_strobe_n), .recency_write_n(recency_write_n),
    .way1_hit(way1_hit), .way2_hit(way2_hit), .replace_way(replace_way));

  // Clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Offer one request, wait for its response pulse
  task automatic run_req(input logic fill, input logic [INDEX_W-1:0] idx,
                         input logic [TAG_W-1:0] tag);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_fill <= fill;
    req_index <= idx;
    req_tag <= tag;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    if (n >= 100) begin
      chk(8'h00, 8'h01, "response timeout");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Fill at top index, then hit it
  task automatic t_fill_then_hit();
    run_req(1'b1, IDX_HI, 4'h5);
    chk(rsp_hit, 1'b0, "fill lookup");
    chk(rsp_written, 1'b1, "fill written");
    chk(rsp_way, WAY1, "fill way");
    chk(tlc_dev_model_inst.way1_mem[IDX_HI], {^4'h5, 4'h5}, "stored entry");
    run_req(1'b1, IDX_HI, 4'h5);
    chk(rsp_hit, 1'b1, "lookup hit");
    chk(rsp_way, WAY1, "hit way");
    chk(rsp_written, 1'b0, "hit not rewritten");
    chk(tlc_dev_model_inst.n_writes[7:0], 8'h01, "write count");
    chk(tlc_dev_model_inst.recency[IDX_HI], 1'b1, "recency after way one");
    $display("test fill_then_hit done");
  endtask

  // Second fill goes to way two, then hits move recency both ways
  task automatic t_second_way();
    run_req(1'b1, IDX_HI, 4'hA);
    chk(rsp_way, WAY2, "second fill way");
    chk(tlc_dev_model_inst.way2_mem[IDX_HI], {^4'hA, 4'hA}, "second entry");
    chk(tlc_dev_model_inst.recency[IDX_HI], 1'b0, "recency inverted");
    run_req(1'b0, IDX_HI, 4'h5);
    chk(tlc_dev_model_inst.recency[IDX_HI], 1'b1, "recency set");
    run_req(1'b0, IDX_HI, 4'hA);
    chk(rsp_hit, 1'b1, "way two hit");
    chk(rsp_way, WAY2, "way two data");
    chk(tlc_dev_model_inst.recency[IDX_HI], 1'b0, "recency cleared");
    $display("test second_way done");
  endtask

  // Miss without fill writes nothing
  task automatic t_miss_no_fill();
    run_req(1'b0, IDX_HI, 4'h3);
    chk(rsp_hit, 1'b0, "plain miss");
    chk(rsp_written, 1'b0, "plain miss written");
    chk(rsp_way, WAY1, "plain miss way");
    chk(tlc_dev_model_inst.n_writes[7:0], 8'h02, "write count");
    chk(tlc_dev_model_inst.recency[IDX_HI], 1'b0, "recency kept");
    $display("test miss_no_fill done");
  endtask

  // Lowest index is independent of the top one
  task automatic t_low_index();
    run_req(1'b1, 13'h0000, 4'hB);
    chk(rsp_way, WAY1, "low index way");
    chk(tlc_dev_model_inst.way1_mem[0], 8'h1B, "odd parity entry");
    chk(tlc_dev_model_inst.recency[0], 1'b1, "low recency");
    chk(tlc_dev_model_inst.recency[IDX_HI], 1'b0, "top recency");
    $display("test low_index done");
  endtask

  // Reset in the middle of a write pulse returns the pins to idle
  task automatic t_mid_reset();
    req_valid <= 1'b1;
    req_fill <= 1'b1;
    req_index <= 13'h0ABC;
    req_tag <= 4'h6;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (7) @(posedge clk_sys);
    chk(write_strobe_n, 1'b0, "strobe low before reset");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(write_strobe_n, 1'b1, "strobe after reset");
    chk(select_n, 1'b1, "select after reset");
    chk(recency_write_n, 1'b1, "recency strobe after reset");
    chk(req_ready, 1'b1, "ready after reset");
    chk(rsp_valid, 1'b0, "response after reset");
    chk(tlc_dev_model_inst.n_writes[7:0], 8'h04, "cut write count");
    run_req(1'b0, 13'h0ABC, 4'h6);
    chk(rsp_hit, 1'b1, "hit after reset");
    chk(rsp_way, WAY1, "way after reset");
    $display("test mid_reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_fill_then_hit();
    t_second_way();
    t_miss_no_fill();
    t_low_index();
    t_mid_reset();
    report_and_stop();
  end

  // Watchdog
  initial begin
    #50000;
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
